// ==== hdl/cpu_module_pkg.sv ====
/*
  constants for the cpu module clock and bus control logic: counter
  preset and phase decode points, status word bit positions.
  assumes one 25 mhz clock stands in for the oscillator input.
*/
package cpu_module_pkg;

  // ----------------------------------------------------------------
  // clock generator
  // ----------------------------------------------------------------
  localparam int osc_mhz = 20;
  localparam int clk_mhz = 25;
  localparam int counter_width = 4;
  localparam logic [3:0] counter_preset = 4'h6;
  localparam logic [3:0] counter_last = 4'hf;
  localparam logic [3:0] phase_one_first = 4'h6;
  localparam logic [3:0] phase_one_last = 4'h7;
  localparam logic [3:0] phase_two_first = 4'h9;
  localparam logic [3:0] phase_two_last = 4'hd;
  localparam logic [3:0] adv_phase_one_count = 4'hf;

  // ----------------------------------------------------------------
  // status word bit positions
  // ----------------------------------------------------------------
  localparam int status_width = 8;
  localparam int st_int_ack = 0;
  localparam int st_write_out_n = 1;
  localparam int st_stack = 2;
  localparam int st_halt_ack = 3;
  localparam int st_output = 4;
  localparam int st_fetch = 5;
  localparam int st_input = 6;
  localparam int st_mem_read = 7;

  localparam logic [7:0] status_reset = 8'h00;
  localparam logic [7:0] data_reset = 8'h00;

endpackage : cpu_module_pkg

// ==== hdl/phase_clock_gen.sv ====
/*
  phase clock generator: presettable 4-bit counter, phase decode,
  advanced first phase and status strobe.
  assumes clk is the oscillator and cpu_sync is synchronous to it.
*/
`timescale 1ns/1ps
`default_nettype none

module phase_clock_gen (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // processor cycle start
  input wire logic cpu_sync,
  // generated timing
  output logic phase_one,
  output logic phase_two,
  output logic advanced_phase_one,
  output logic status_strobe
);

  typedef struct packed {
    logic [3:0] count;
    logic phase_one;
    logic phase_two;
    logic adv;
    logic strobe;
  } gen_state_type;

  gen_state_type state;
  gen_state_type next_state;

  // ----------------------------------------------------------------
  // counter and decode
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    if (state.count == cpu_module_pkg::counter_last)
      next_state.count = cpu_module_pkg::counter_preset;
    else
      next_state.count = state.count + 4'h1;
    // phase windows are disjoint, so they never overlap
    next_state.phase_one =
      (next_state.count >= cpu_module_pkg::phase_one_first) &&
      (next_state.count <= cpu_module_pkg::phase_one_last);
    next_state.phase_two =
      (next_state.count >= cpu_module_pkg::phase_two_first) &&
      (next_state.count <= cpu_module_pkg::phase_two_last);
    next_state.adv =
      (next_state.count == cpu_module_pkg::adv_phase_one_count);
    next_state.strobe = next_state.adv && cpu_sync;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state <= '{count: cpu_module_pkg::counter_preset, default: 1'b0};
    else
      state <= next_state;
  end

  assign phase_one = state.phase_one;
  assign phase_two = state.phase_two;
  assign advanced_phase_one = state.adv;
  assign status_strobe = state.strobe;

endmodule : phase_clock_gen

`default_nettype wire

// ==== hdl/status_latch.sv ====
/*
  8-bit status latch loaded by the status strobe.
  assumes data is still valid in the cycle the strobe is high.
*/
`timescale 1ns/1ps
`default_nettype none

module status_latch (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // load
  input wire logic load,
  input wire logic [7:0] data,
  // latched word
  output logic [7:0] status
);

  typedef struct packed {
    logic [7:0] word;
  } latch_state_type;

  latch_state_type state;
  latch_state_type next_state;

  always_comb
  begin
    next_state = state;
    if (load)
      next_state.word = data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state <= '{word: cpu_module_pkg::status_reset};
    else
      state <= next_state;
  end

  assign status = state.word;

endmodule : status_latch

`default_nettype wire

// ==== hdl/cpu_bus_control.sv ====
/*
  cpu module clock and bus control: clock phases, status capture,
  data bus buffer direction and release, control bus commands.
  assumes all inputs are synchronous to clk; bidirectional pins are
  split into in, out and output enable, resolved outside.

*/
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_control (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // processor control
  input wire logic cpu_sync,
  input wire logic cpu_data_in_strobe,
  input wire logic cpu_write_n,
  // processor data pins
  input wire logic [7:0] cpu_data_in,
  output logic [7:0] cpu_data_out,
  output logic cpu_data_oe,
  // system data bus
  input wire logic [7:0] sys_data_in,
  output logic [7:0] sys_data_out,
  output logic sys_data_oe,
  // dma release, low hands the bus over
  input wire logic bus_release_n,
  // external requests
  input wire logic hold_request,
  input wire logic ready_request,
  output logic hold_sync,
  output logic ready_sync,
  // clock outputs
  output logic phase_one,
  output logic phase_two,
  output logic advanced_phase_one,
  output logic status_strobe,
  // buffer direction, high means toward processor
  output logic buffer_direction_ctl,
  // control bus
  output logic mem_read_cmd,
  output logic mem_write_cmd,
  output logic io_read_cmd,
  output logic io_write_cmd,
  output logic interrupt_ack_cmd,
  // auxiliary status
  output logic fetch_status,
  output logic stack_status,
  output logic halt_status,
  output logic write_out_n_status,
  output logic [7:0] status_word
);

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  logic [7:0] latched_status;

  phase_clock_gen clock_gen (
    .clk(clk),
    .rst(rst),
    .cpu_sync(cpu_sync),
    .phase_one(phase_one),
    .phase_two(phase_two),
    .advanced_phase_one(advanced_phase_one),
    .status_strobe(status_strobe)
  );

  // fed from processor-side pins so capture works while released
  status_latch latch (
    .clk(clk),
    .rst(rst),
    .load(status_strobe),
    .data(cpu_data_in),
    .status(latched_status)
  );

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic st_bit(input logic [7:0] word, input int pos);
    st_bit = word[pos];
  endfunction : st_bit

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hold_sync;
    logic ready_sync;
    logic [7:0] cpu_data_out;
    logic cpu_data_oe;
    logic [7:0] sys_data_out;
    logic sys_data_oe;
    logic direction;
    logic mem_read;
    logic mem_write;
    logic io_read;
    logic io_write;
    logic int_ack;
    logic fetch;
    logic stack;
    logic halt;
    logic write_out_n;
  } ctl_state_type;

  ctl_state_type state;
  ctl_state_type next_state;

  logic write_active;
  assign write_active = ~cpu_write_n;

  always_comb
  begin
    next_state = state;

    // --------------------------------------------------------------
    // request synchronizers
    // --------------------------------------------------------------
    if (advanced_phase_one)
    begin
      next_state.hold_sync = hold_request;
      next_state.ready_sync = ready_request;
    end

    // --------------------------------------------------------------
    // data bus buffer
    // --------------------------------------------------------------
    next_state.direction = cpu_data_in_strobe;
    next_state.cpu_data_out = sys_data_in;
    next_state.sys_data_out = cpu_data_in;
    if (!bus_release_n)
    begin
      next_state.cpu_data_oe = 1'b0;
      next_state.sys_data_oe = 1'b0;
    end
    else if (cpu_data_in_strobe)
    begin
      next_state.cpu_data_oe = 1'b1;
      next_state.sys_data_oe = 1'b0;
    end
    else
    begin
      next_state.cpu_data_oe = 1'b0;
      next_state.sys_data_oe = 1'b1;
    end

    // --------------------------------------------------------------
    // control bus commands
    // --------------------------------------------------------------
    next_state.mem_read = cpu_data_in_strobe &&
      st_bit(latched_status, cpu_module_pkg::st_mem_read);
    next_state.io_read = cpu_data_in_strobe &&
      st_bit(latched_status, cpu_module_pkg::st_input);
    next_state.mem_write = write_active &&
      !st_bit(latched_status, cpu_module_pkg::st_output);
    next_state.io_write = write_active &&
      st_bit(latched_status, cpu_module_pkg::st_output);
    next_state.int_ack = cpu_data_in_strobe &&
      st_bit(latched_status, cpu_module_pkg::st_int_ack);

    // --------------------------------------------------------------
    // auxiliary status
    // --------------------------------------------------------------
    next_state.fetch = st_bit(latched_status, cpu_module_pkg::st_fetch);
    next_state.stack = st_bit(latched_status, cpu_module_pkg::st_stack);
    next_state.halt = st_bit(latched_status, cpu_module_pkg::st_halt_ack);
    next_state.write_out_n =
      st_bit(latched_status, cpu_module_pkg::st_write_out_n);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= '{cpu_data_out: cpu_module_pkg::data_reset,
                 sys_data_out: cpu_module_pkg::data_reset,
                 write_out_n: 1'b1,
                 default: 1'b0};
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hold_sync = state.hold_sync;
  assign ready_sync = state.ready_sync;
  assign cpu_data_out = state.cpu_data_out;
  assign cpu_data_oe = state.cpu_data_oe;
  assign sys_data_out = state.sys_data_out;
  assign sys_data_oe = state.sys_data_oe;
  assign buffer_direction_ctl = state.direction;
  assign mem_read_cmd = state.mem_read;
  assign mem_write_cmd = state.mem_write;
  assign io_read_cmd = state.io_read;
  assign io_write_cmd = state.io_write;
  assign interrupt_ack_cmd = state.int_ack;
  assign fetch_status = state.fetch;
  assign stack_status = state.stack;
  assign halt_status = state.halt;
  assign write_out_n_status = state.write_out_n;
  assign status_word = latched_status;

endmodule : cpu_bus_control

`default_nettype wire

// ==== verif/cpu_bus_control_asserts.sv ====
/*
  port timing checker for cpu_bus_control.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_control_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // processor side
  input wire logic cpu_sync,
  input wire logic cpu_data_in_strobe,
  input wire logic cpu_write_n,
  input wire logic [7:0] cpu_data_in,
  input wire logic bus_release_n,
  // timing
  input wire logic phase_one,
  input wire logic phase_two,
  input wire logic advanced_phase_one,
  input wire logic status_strobe,
  input wire logic [7:0] status_word,
  // buffer and commands
  input wire logic buffer_direction_ctl,
  input wire logic cpu_data_oe,
  input wire logic sys_data_oe,
  input wire logic [7:0] sys_data_out,
  input wire logic mem_read_cmd,
  input wire logic mem_write_cmd,
  input wire logic io_read_cmd,
  input wire logic io_write_cmd,
  input wire logic interrupt_ack_cmd
);
  // first edge after reset still sees reset-time history
  logic rst_d;
  always_ff @(posedge clk) rst_d <= rst;
  default clocking @(posedge clk); endclocking
  default disable iff (rst || rst_d);

  a_phase_excl: assert property (
    !(phase_one && phase_two)) else $error("phases overlap");
  a_adv_period: assert property (
    advanced_phase_one |=> (!advanced_phase_one)[*8]
    ##1 !advanced_phase_one ##1 advanced_phase_one)
    else $error("advanced phase period wrong");
  a_strobe_gate: assert property (
    status_strobe == (advanced_phase_one && $past(cpu_sync)))
    else $error("status strobe gating wrong");
  a_latch_load: assert property (
    status_strobe |=> status_word == $past(cpu_data_in))
    else $error("status not loaded");
  a_latch_hold: assert property (
    !status_strobe |=> $stable(status_word))
    else $error("status changed without strobe");
  a_mem_read: assert property (
    mem_read_cmd == $past(cpu_data_in_strobe && status_word[7]))
    else $error("memory read command wrong");
  a_io_read: assert property (
    io_read_cmd == $past(cpu_data_in_strobe && status_word[6]))
    else $error("io read command wrong");
  a_mem_write: assert property (
    mem_write_cmd == $past(!cpu_write_n && !status_word[4]))
    else $error("memory write command wrong");
  a_io_write: assert property (
    io_write_cmd == $past(!cpu_write_n && status_word[4]))
    else $error("io write command wrong");
  a_int_ack: assert property (
    interrupt_ack_cmd == $past(cpu_data_in_strobe && status_word[0]))
    else $error("interrupt ack command wrong");
  a_dir_follow: assert property (
    buffer_direction_ctl == $past(cpu_data_in_strobe))
    else $error("buffer direction wrong");
  a_dma_release: assert property (
    !bus_release_n |=> !sys_data_oe && !cpu_data_oe)
    else $error("buffer drives while released");
  a_data_out: assert property (
    sys_data_oe |-> sys_data_out == $past(cpu_data_in))
    else $error("system data wrong");

  c_strobe: cover property (status_strobe);
  c_read: cover property (mem_read_cmd);
  c_dma: cover property (!bus_release_n && cpu_data_in_strobe);
endmodule : cpu_bus_control_asserts

`default_nettype wire

// ==== verif/system_bus_device.sv ====
/*
  memory and io device model on the system data bus.
  assumes the bench resolves the bus level from all drivers.
*/
`timescale 1ns/1ps
`default_nettype none

module system_bus_device (
  // clock
  input wire logic clk,
  // control bus
  input wire logic mem_read_cmd,
  input wire logic mem_write_cmd,
  input wire logic io_read_cmd,
  input wire logic io_write_cmd,
  // data bus
  input wire logic [7:0] bus_level,
  output logic [7:0] dev_data
);
  logic [7:0] mem_byte = 8'h00;
  logic [7:0] io_byte = 8'h00;
  logic [7:0] last_level = 8'h00;
  // released bus shows a changing pattern, not the last value
  always_comb
  begin
    if (mem_read_cmd)
      dev_data = mem_byte;
    else if (io_read_cmd)
      dev_data = io_byte;
    else
      dev_data = ~last_level;
  end
  always_ff @(posedge clk)
  begin
    last_level <= bus_level;
    if (mem_write_cmd)
      mem_byte <= bus_level;
    if (io_write_cmd)
      io_byte <= bus_level;
  end
endmodule : system_bus_device

`default_nettype wire

// ==== verif/tb_cpu_bus_control.sv ====
/*
  self-checking bench for cpu_bus_control with a bus device model.
  assumes the checker and device model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_cpu_bus_control;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cpu_sync = 1'b0;
  logic cpu_data_in_strobe = 1'b0;
  logic cpu_write_n = 1'b1;
  logic [7:0] cpu_data_in = 8'h00;
  logic bus_release_n = 1'b1;
  logic hold_request = 1'b0;
  logic ready_request = 1'b0;
  logic [7:0] sys_data_in, sys_data_out, cpu_data_out, dev_data;
  logic [7:0] status_word;
  logic cpu_data_oe, sys_data_oe, hold_sync, ready_sync;
  logic phase_one, phase_two, advanced_phase_one, status_strobe;
  logic buffer_direction_ctl, mem_read_cmd, mem_write_cmd;
  logic io_read_cmd, io_write_cmd, interrupt_ack_cmd;
  logic fetch_status, stack_status, halt_status, write_out_n_status;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #20 clk = ~clk;
  assign sys_data_in = sys_data_oe ? sys_data_out : dev_data;

  cpu_bus_control dut (.*);
  system_bus_device device (.clk, .mem_read_cmd, .mem_write_cmd,
    .io_read_cmd, .io_write_cmd, .bus_level(sys_data_in), .dev_data);

  task automatic close_out();
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one machine cycle: status at cycle start, then strobes
  task automatic m_cycle(input logic [7:0] st, input logic rd, wr, rel,
    input logic [7:0] dat);
    int n;
    n = 0;
    @(negedge clk);
    while (advanced_phase_one !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    repeat (8) @(negedge clk);
    bus_release_n = rel;
    cpu_sync = 1'b1;
    cpu_data_in = st;
    repeat (2) @(negedge clk);
    check("strobe", status_strobe, 1'b1);
    cpu_sync = 1'b0;
    repeat (2) @(negedge clk);
    check("status", status_word, st);
    cpu_data_in_strobe = rd;
    cpu_write_n = !wr;
    cpu_data_in = dat;
    @(negedge clk);
    check("memr", mem_read_cmd, rd & st[7]);
    check("ior", io_read_cmd, rd & st[6]);
    check("memw", mem_write_cmd, wr & !st[4]);
    check("iow", io_write_cmd, wr & st[4]);
    check("interrupt_ack_cmd", interrupt_ack_cmd, rd & st[0]);
    check("fetch", fetch_status, st[5]);
    check("stack", stack_status, st[2]);
    check("halt", halt_status, st[3]);
    check("wo", write_out_n_status, st[1]);
    check("dir", buffer_direction_ctl, rd);
    check("cpu_oe", cpu_data_oe, rd & rel);
    check("sys_oe", sys_data_oe, !rd & rel);
    if (wr) check("sys_data", sys_data_out, dat);
    cpu_data_in_strobe = 1'b0;
    cpu_write_n = 1'b1;
    @(negedge clk);
  endtask : m_cycle

  task automatic test_timing();
    int adv, both, p1, p2;
    adv = 0;
    both = 0;
    p1 = 0;
    p2 = 0;
    hold_request = 1'b1;
    ready_request = 1'b1;
    repeat (40)
    begin
      @(negedge clk);
      adv += advanced_phase_one;
      both += phase_one & phase_two;
      p1 += phase_one;
      p2 += phase_two;
    end
    check("adv", adv[7:0], 8'h04);
    check("overlap", both[7:0], 8'h00);
    check("phase_one", p1[7:0], 8'h08);
    check("phase_two", p2[7:0], 8'h14);
    check("hold", hold_sync, 1'b1);
    check("ready", ready_sync, 1'b1);
    hold_request = 1'b0;
  endtask : test_timing

  task automatic test_mem_io();
    m_cycle(8'h00, 1'b0, 1'b1, 1'b1, 8'h5a);
    m_cycle(8'h10, 1'b0, 1'b1, 1'b1, 8'ha5);
    m_cycle(8'h82, 1'b1, 1'b0, 1'b1, 8'h00);
    check("mem_rd", cpu_data_out, 8'h5a);
    m_cycle(8'h42, 1'b1, 1'b0, 1'b1, 8'h00);
    check("io_rd", cpu_data_out, 8'ha5);
  endtask : test_mem_io

  task automatic test_ack_dma();
    m_cycle(8'h23, 1'b1, 1'b0, 1'b1, 8'h00);
    m_cycle(8'h82, 1'b1, 1'b0, 1'b0, 8'h00);
    bus_release_n = 1'b1;
  endtask : test_ack_dma

  // mid-run reset: outputs return to reset values, timing restarts
  task automatic test_reset();
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    check("rst_status", status_word, cpu_module_pkg::status_reset);
    check("rst_wo", write_out_n_status, 1'b1);
    check("rst_ready", ready_sync, 1'b0);
    check("rst_sys_oe", sys_data_oe, 1'b0);
    check("rst_phase", phase_one, 1'b0);
    rst = 1'b0;
    ready_request = 1'b0;
    @(negedge clk);
    check("rel_phase", phase_one, 1'b1);
    check("rel_sys_oe", sys_data_oe, 1'b1);
    repeat (7) @(negedge clk);
    check("rel_adv_early", advanced_phase_one, 1'b0);
    @(negedge clk);
    check("rel_adv", advanced_phase_one, 1'b1);
    m_cycle(8'h82, 1'b1, 1'b0, 1'b1, 8'h00);
    check("rst_rd", cpu_data_out, 8'h5a);
  endtask : test_reset

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      close_out();
    end
  end

  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    test_timing();
    test_mem_io();
    test_ack_dma();
    test_reset();
    close_out();
  end
endmodule : tb_cpu_bus_control

bind cpu_bus_control cpu_bus_control_asserts checker_i (.clk, .rst,
  .cpu_sync, .cpu_data_in_strobe, .cpu_write_n, .cpu_data_in,
  .bus_release_n, .phase_one, .phase_two, .advanced_phase_one,
  .status_strobe, .status_word, .buffer_direction_ctl, .cpu_data_oe,
  .sys_data_oe, .sys_data_out, .mem_read_cmd, .mem_write_cmd,
  .io_read_cmd, .io_write_cmd, .interrupt_ack_cmd);

`default_nettype wire
